// File: efc_array_model.sv
// Behavioural model of the flash array macro on the far side of the controller
module efc_array_model
  import efc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Array side of the controller
  input efc_array_t arr,
  output logic [31:0] rdata
);
  logic [31:0] mem [16];
  logic [31:0] last_q;

  initial begin
    foreach (mem[i]) mem[i] = 32'hffffffff;
    last_q = 32'h0;
  end

  // Programming only clears bits, so a missing erase shows up as corrupt data
  always @(posedge clk) begin
    if (arr.erase_en) begin
      foreach (mem[i]) mem[i] <= 32'hffffffff;
    end else if (arr.prog_en && arr.program_strobe) begin
      mem[arr.addr[3:0]] <= mem[arr.addr[3:0]] & arr.wdata;
    end
    if (arr.read_en) begin
      last_q <= mem[arr.addr[3:0]];
    end
  end

  // Outside a read the lines carry the inverse of the last word, never stale data
  assign rdata = arr.read_en ? mem[arr.addr[3:0]] : ~last_q;
endmodule : efc_array_model

// File: efc_flash_ctrl.sv
// Flash program/erase sequencer with APB register file
// What this block does
// - Read-lock bit blocks array reads; software only sets it, reset clears it.
// - Write-lock bit blocks writes and erases; software only sets it.
// - General lock bit blocks all array access; software sets and clears it.
// - Read-inhibit status is one after write or erase until reads are allowed.
// - Erase-busy status is one while an erase cycle runs.
// - Write-busy status is one while a write cycle runs.
// - Access-kind select zero means read, one permits erase or write.
// - Writing one to the sleep request bit puts the array to sleep.
// - A read wakes the array; wake-up lasts wake count microseconds.
// - Operation select: 00 none, 01 write, 10 page erase, 11 bulk erase.
// - Bulk erase from info block erases info and main; else main only.
// - Program strobe hold lasts strobe hold count microseconds unless the last erase was a mass erase.
// - Each programming pulse lasts program pulse count microseconds.
// - Page erase lasts page erase count microseconds.
// - Mass erase lasts mass erase count microseconds.
// - Suspendable page erase runs in segments of segment count microseconds.
// - Total erase progress counter is readable, resets to zero.
// - Segment erase progress counter is readable, resets to zero.
// - Erase suspension works only with its enable bit set.
// - Suspend mode one stalls reads to segment end; zero suspends at once.
// - Sleep status reads one after reset, cleared by next array access, read or write.
//
// Chosen here: the APB interface to the registers.
module efc_flash_ctrl
  import efc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Array access requests from the system
  input efc_fa_req_t FA_REQ,
  output efc_fa_rsp_t FA_RSP,
  // Flash array macro
  output efc_array_t ARRAY,
  input wire logic [31:0] ARRAY_RDATA
);

  efc_state_t st_q;
  efc_state_t st_d;
  logic tick;
  logic apb_setup;
  logic apb_wr;
  logic sleep_set;
  logic rd_req;
  logic [23:0] tot_dec;
  logic [23:0] seg_dec;

  function automatic efc_reg_t reg_sel(input logic [31:0] a);
    case (a)
      OFS_CTRL: reg_sel = R_CTRL;
      OFS_HOLD: reg_sel = R_HOLD;
      OFS_PULSE: reg_sel = R_PULSE;
      OFS_PAGE: reg_sel = R_PAGE;
      OFS_MASS: reg_sel = R_MASS;
      OFS_WAKE: reg_sel = R_WAKE;
      OFS_SEG: reg_sel = R_SEG;
      OFS_TOT_CNT: reg_sel = R_TOT;
      OFS_SEG_CNT: reg_sel = R_SEGC;
      default: reg_sel = R_NONE;
    endcase
  endfunction : reg_sel

  function automatic logic [31:0] ctrl_word(input efc_state_t s);
    logic [31:0] w;
    w = '0;
    w[B_MODE_HI:B_MODE_LO] = s.mode;
    w[B_SEL] = s.sel;
    w[B_WRS] = s.wrs;
    w[B_ERS] = s.ers;
    w[B_INHIBIT] = s.inhibit;
    w[B_PROT] = s.prot;
    w[B_WPROT] = s.wprot;
    w[B_RPROT] = s.rprot;
    w[B_SLEEP] = s.sleep;
    w[B_SUSP_EN] = s.susp_en;
    w[B_SUSP_MODE] = s.susp_mode;
    w[B_SUSPENDED] = s.suspended;
    ctrl_word = w;
  endfunction : ctrl_word

  function automatic logic [31:0] rd_word(input efc_state_t s, input efc_reg_t r);
    case (r)
      R_CTRL: rd_word = ctrl_word(s);
      R_HOLD: rd_word = {16'h0000, s.hold_t};
      R_PULSE: rd_word = {16'h0000, s.pulse_t};
      R_PAGE: rd_word = {8'h00, s.page_t};
      R_MASS: rd_word = {8'h00, s.mass_t};
      R_WAKE: rd_word = {24'h000000, s.wake_t};
      R_SEG: rd_word = {8'h00, s.seg_t};
      R_TOT: rd_word = {8'h00, s.tot};
      R_SEGC: rd_word = {8'h00, s.seg};
      default: rd_word = 32'h0000_0000;
    endcase
  endfunction : rd_word

  // A count of zero ends on the first tick, so no duration can hang
  function automatic logic last_tick(input logic [23:0] c);
    last_tick = (c <= 24'h000001);
  endfunction : last_tick

  efc_usec_tick #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .tick(tick)
  );

  assign apb_setup = PSEL & ~PENABLE;
  assign apb_wr = PSEL & PENABLE & PWRITE;
  assign rd_req = FA_REQ.req & ~FA_REQ.write & ~st_q.rsp.done; // Held request not taken twice
  assign tot_dec = (st_q.tot != 24'h000000) ? st_q.tot - 24'h000001 : st_q.tot;
  assign seg_dec = (st_q.seg != 24'h000000) ? st_q.seg - 24'h000001 : st_q.seg;

  always_comb begin
    st_d = st_q;
    sleep_set = 1'b0;
    st_d.rsp.done = 1'b0;
    st_d.rsp.err = 1'b0;
    // Read data is sampled in the setup phase and shown in the access phase
    if (apb_setup) begin
      st_d.prdata = rd_word(st_q, reg_sel(PADDR));
    end
    if (apb_wr) begin
      case (reg_sel(PADDR))
        R_CTRL: begin
          st_d.rprot = st_q.rprot | PWDATA[B_RPROT];
          st_d.wprot = st_q.wprot | PWDATA[B_WPROT];
          st_d.prot = PWDATA[B_PROT];
          st_d.sel = PWDATA[B_SEL];
          st_d.mode = PWDATA[B_MODE_HI:B_MODE_LO];
          st_d.susp_en = PWDATA[B_SUSP_EN];
          st_d.susp_mode = PWDATA[B_SUSP_MODE];
          sleep_set = PWDATA[B_SLEEP_REQ];
        end
        R_HOLD: st_d.hold_t = PWDATA[15:0];
        R_PULSE: st_d.pulse_t = PWDATA[15:0];
        R_PAGE: st_d.page_t = PWDATA[23:0];
        R_MASS: st_d.mass_t = PWDATA[23:0];
        R_WAKE: st_d.wake_t = PWDATA[7:0];
        R_SEG: st_d.seg_t = PWDATA[23:0];
        default: begin
        end
      endcase
    end
    case (st_q.fsm)
      S_IDLE: begin
        if (FA_REQ.req && !st_q.rsp.done) begin
          st_d.op_wr = FA_REQ.write;
          st_d.op_addr = FA_REQ.addr;
          st_d.op_wdata = FA_REQ.wdata;
          if (st_q.sleep) begin
            st_d.cnt = {16'h0000, st_q.wake_t};
            st_d.fsm = S_WAKE;
          end else begin
            st_d.fsm = S_DISPATCH;
          end
        end
      end
      S_WAKE: begin
        if (tick) begin
          st_d.cnt = st_q.cnt - 24'h000001;
          if (last_tick(st_q.cnt)) begin
            st_d.sleep = 1'b0;
            st_d.fsm = S_DISPATCH;
          end
        end
      end
      S_DISPATCH: begin
        if (!st_q.op_wr) begin
          if (st_q.rprot || st_q.prot) begin
            st_d.rsp.done = 1'b1;
            st_d.rsp.err = 1'b1;
            st_d.fsm = st_q.suspended ? S_ERASE : S_IDLE;
            st_d.suspended = 1'b0;
          end else begin
            st_d.fsm = S_READ;
          end
        end else if (st_q.wprot || st_q.prot || !st_q.sel || st_q.mode == OP_NONE) begin
          st_d.rsp.done = 1'b1;
          st_d.rsp.err = 1'b1;
          st_d.fsm = S_IDLE;
        end else begin
          st_d.rsp.done = 1'b1;
          st_d.inhibit = 1'b1;
          if (st_q.mode == OP_WRITE) begin
            st_d.wrs = 1'b1;
            st_d.cnt = {8'h00, st_q.pulse_t};
            st_d.fsm = S_PULSE;
          end else begin
            st_d.ers = 1'b1;
            st_d.mass = (st_q.mode == OP_MASS);
            st_d.info = st_q.op_addr[INFO_BIT];
            st_d.tot = (st_q.mode == OP_MASS) ? st_q.mass_t : st_q.page_t;
            st_d.seg = st_q.seg_t;
            st_d.seg_start = st_d.tot;
            st_d.stall = 1'b0;
            st_d.fsm = S_ERASE;
          end
        end
      end
      S_READ: begin
        st_d.rsp.rdata = ARRAY_RDATA;
        st_d.rsp.done = 1'b1;
        st_d.fsm = st_q.suspended ? S_ERASE : S_IDLE;
        st_d.suspended = 1'b0;
      end
      S_PULSE: begin
        if (tick) begin
          st_d.cnt = st_q.cnt - 24'h000001;
          if (last_tick(st_q.cnt)) begin
            st_d.wrs = 1'b0;
            st_d.cnt = {8'h00, st_q.hold_t};
            st_d.fsm = S_HOLD;
          end
        end
      end
      S_HOLD: begin
        if (tick) begin
          st_d.cnt = st_q.cnt - 24'h000001;
          if (last_tick(st_q.cnt)) begin
            st_d.inhibit = 1'b0;
            st_d.fsm = S_IDLE;
          end
        end
      end
      S_ERASE: begin
        if (tick) begin
          st_d.tot = tot_dec;
          st_d.seg = seg_dec;
        end
        if (tick && last_tick(st_q.tot)) begin
          st_d.ers = 1'b0;
          st_d.tot = 24'h000000;
          st_d.stall = 1'b0;
          st_d.cnt = {8'h00, st_q.hold_t};
          st_d.fsm = S_HOLD;
        end else if (tick && last_tick(st_q.seg)) begin
          st_d.seg = st_q.seg_t;
          st_d.seg_start = tot_dec;
          // Mass erase is never split, so only page erase may pause here
          if (st_q.stall || (rd_req && st_q.susp_en && !st_q.mass)) begin
            st_d.stall = 1'b0;
            st_d.suspended = 1'b1;
            st_d.op_wr = 1'b0;
            st_d.op_addr = FA_REQ.addr;
            st_d.fsm = S_DISPATCH;
          end
        end else if (rd_req && st_q.susp_en && !st_q.mass && !st_q.stall) begin
          if (st_q.susp_mode) begin
            st_d.stall = 1'b1;
          end else begin
            // Elapsed part of the segment is given back to the total
            st_d.tot = st_q.seg_start;
            st_d.seg = st_q.seg_t;
            st_d.suspended = 1'b1;
            st_d.op_wr = 1'b0;
            st_d.op_addr = FA_REQ.addr;
            st_d.fsm = S_DISPATCH;
          end
        end
      end
      default: st_d.fsm = S_IDLE;
    endcase
    // A sleep request beats the wake-up clearing it in the same cycle
    if (sleep_set) begin
      st_d.sleep = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= '0;
      st_q.fsm <= S_IDLE;
      st_q.sleep <= 1'b1;
      st_q.hold_t <= RST_HOLD;
      st_q.pulse_t <= RST_PULSE;
      st_q.page_t <= RST_PAGE;
      st_q.mass_t <= RST_MASS;
      st_q.wake_t <= RST_WAKE;
      st_q.seg_t <= RST_SEG;
    end else begin
      st_q <= st_d;
    end
  end

  assign PRDATA = st_q.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & (reg_sel(PADDR) == R_NONE);
  assign FA_RSP = st_q.rsp;

  always_comb begin
    ARRAY = '0;
    ARRAY.read_en = (st_q.fsm == S_READ);
    ARRAY.prog_en = (st_q.fsm == S_PULSE);
    ARRAY.program_strobe = (st_q.fsm == S_PULSE) || (st_q.fsm == S_HOLD && st_q.wrs == 1'b0
                           && st_q.ers == 1'b0 && !st_q.mass && st_q.op_wr);
    ARRAY.erase_en = (st_q.fsm == S_ERASE) && !st_q.stall;
    ARRAY.mass_en = (st_q.fsm == S_ERASE) && st_q.mass;
    ARRAY.info_sel = st_q.info;
    ARRAY.sleep = st_q.sleep;
    ARRAY.addr = st_q.op_addr;
    ARRAY.wdata = st_q.op_wdata;
  end

  property p_rprot_sticky;
    @(posedge CLK_SYS) disable iff (!RST_B)
    st_q.rprot |=> st_q.rprot;
  endproperty
  a_rprot_sticky: assert property (p_rprot_sticky) else $error("read lock dropped");

  property p_wr_lock;
    @(posedge CLK_SYS) disable iff (!RST_B)
    $rose(st_q.wrs) || $rose(st_q.ers) |-> !$past(st_q.wprot);
  endproperty
  a_wr_lock: assert property (p_wr_lock) else $error("write under write lock");

  property p_prot;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (st_q.fsm == S_READ) |-> !st_q.prot && !st_q.rprot;
  endproperty
  a_prot: assert property (p_prot) else $error("read under lock");

  property p_inhibit;
    @(posedge CLK_SYS) disable iff (!RST_B)
    (st_q.wrs || st_q.ers) |-> st_q.inhibit;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit low while busy");

  property p_ers;
    @(posedge CLK_SYS) disable iff (!RST_B)
    ARRAY.erase_en |-> st_q.ers;
  endproperty
  a_ers: assert property (p_ers) else $error("erase without busy flag");

  property p_wrs;
    @(posedge CLK_SYS) disable iff (!RST_B)
    $rose(ARRAY.prog_en) |-> st_q.wrs && $past(st_q.sel) && $past(st_q.mode) == OP_WRITE;
  endproperty
  a_wrs: assert property (p_wrs) else $error("write without busy or select");

  property p_sleep_req;
    @(posedge CLK_SYS) disable iff (!RST_B)
    apb_wr && reg_sel(PADDR) == R_CTRL && PWDATA[B_SLEEP_REQ] |=> ARRAY.sleep;
  endproperty
  a_sleep_req: assert property (p_sleep_req) else $error("sleep request ignored");

  property p_wake;
    @(posedge CLK_SYS) disable iff (!RST_B)
    $fell(st_q.sleep) |-> $past(st_q.fsm) == S_WAKE && $past(tick);
  endproperty
  a_wake: assert property (p_wake) else $error("sleep cleared outside wake");

  property p_tick;
    @(posedge CLK_SYS) disable iff (!RST_B)
    tick |=> !tick [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("tick too frequent");

  property p_tot_dec;
    @(posedge CLK_SYS) disable iff (!RST_B)
    st_q.fsm == S_ERASE && tick && !FA_REQ.req && st_q.tot > 24'h000001
      |=> st_q.tot == $past(st_q.tot) - 24'h000001;
  endproperty
  a_tot_dec: assert property (p_tot_dec) else $error("total counter not decremented");

  property p_suspend_mode0;
    @(posedge CLK_SYS) disable iff (!RST_B)
    st_q.fsm == S_ERASE && rd_req && st_q.susp_en && !st_q.susp_mode && !st_q.mass
      && !st_q.stall && !tick |=> st_q.suspended && st_q.tot == $past(st_q.seg_start);
  endproperty
  a_suspend_mode0: assert property (p_suspend_mode0) else $error("no immediate suspend");

  property p_no_suspend;
    @(posedge CLK_SYS) disable iff (!RST_B)
    !st_q.susp_en && !$past(st_q.susp_en) |-> !$rose(st_q.suspended);
  endproperty
  a_no_suspend: assert property (p_no_suspend) else $error("suspend while disabled");

endmodule : efc_flash_ctrl

// File: efc_pkg.sv
// Shared constants, register map and types for the embedded flash controller
package efc_pkg;

  // Timing base
  localparam int CLK_PERIOD_NS = 50;
  localparam int USEC_NS = 1000;
  localparam int TICK_CYCLES = (USEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 8;

  // Array access port
  localparam int FA_AW = 18;
  localparam int INFO_BIT = FA_AW - 1;

  // Register byte addresses
  localparam logic [31:0] OFS_CTRL = 32'h5006_0100;
  localparam logic [31:0] OFS_HOLD = 32'h5006_0104;
  localparam logic [31:0] OFS_PULSE = 32'h5006_0108;
  localparam logic [31:0] OFS_PAGE = 32'h5006_010c;
  localparam logic [31:0] OFS_MASS = 32'h5006_0110;
  localparam logic [31:0] OFS_WAKE = 32'h5006_0114;
  localparam logic [31:0] OFS_SEG = 32'h5006_0118;
  localparam logic [31:0] OFS_TOT_CNT = 32'h5006_011c;
  localparam logic [31:0] OFS_SEG_CNT = 32'h5006_0120;

  // Control/status field positions
  localparam int B_MODE_LO = 0;
  localparam int B_MODE_HI = 1;
  localparam int B_SLEEP_REQ = 2;
  localparam int B_SEL = 3;
  localparam int B_WRS = 4;
  localparam int B_ERS = 5;
  localparam int B_INHIBIT = 6;
  localparam int B_PROT = 7;
  localparam int B_WPROT = 8;
  localparam int B_RPROT = 9;
  localparam int B_SLEEP = 17;
  localparam int B_SUSP_EN = 18;
  localparam int B_SUSP_MODE = 19;
  localparam int B_SUSPENDED = 20;

  // Reset values
  localparam logic [15:0] RST_HOLD = 16'h0064;
  localparam logic [15:0] RST_PULSE = 16'h0008;
  localparam logic [23:0] RST_PAGE = 24'h013880;
  localparam logic [23:0] RST_MASS = 24'h013880;
  localparam logic [7:0] RST_WAKE = 8'h03;
  localparam logic [23:0] RST_SEG = 24'h0003e8;

  // Operation select encodings
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_PAGE = 2'h2;
  localparam logic [1:0] OP_MASS = 2'h3;

  typedef enum logic [2:0] {
    S_IDLE, S_WAKE, S_DISPATCH, S_READ, S_PULSE, S_HOLD, S_ERASE
  } efc_fsm_t;

  typedef enum logic [3:0] {
    R_CTRL, R_HOLD, R_PULSE, R_PAGE, R_MASS, R_WAKE, R_SEG, R_TOT, R_SEGC, R_NONE
  } efc_reg_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [FA_AW-1:0] addr;
    logic [31:0] wdata;
  } efc_fa_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } efc_fa_rsp_t;

  typedef struct packed {
    logic read_en;
    logic prog_en;
    logic erase_en;
    logic mass_en;
    logic info_sel;
    logic program_strobe;
    logic sleep;
    logic [FA_AW-1:0] addr;
    logic [31:0] wdata;
  } efc_array_t;

  typedef struct packed {
    logic [TICK_W-1:0] cnt;
  } efc_tick_t;

  typedef struct packed {
    efc_fsm_t fsm;
    logic rprot;
    logic wprot;
    logic prot;
    logic inhibit;
    logic ers;
    logic wrs;
    logic sel;
    logic sleep;
    logic susp_en;
    logic susp_mode;
    logic suspended;
    logic stall;
    logic mass;
    logic info;
    logic [1:0] mode;
    logic [15:0] hold_t;
    logic [15:0] pulse_t;
    logic [23:0] page_t;
    logic [23:0] mass_t;
    logic [7:0] wake_t;
    logic [23:0] seg_t;
    logic [23:0] cnt;
    logic [23:0] tot;
    logic [23:0] seg;
    logic [23:0] seg_start;
    logic op_wr;
    logic [FA_AW-1:0] op_addr;
    logic [31:0] op_wdata;
    efc_fa_rsp_t rsp;
    logic [31:0] prdata;
  } efc_state_t;

endpackage : efc_pkg

// File: efc_usec_tick.sv
// One-microsecond tick generator from the system clock
module efc_usec_tick
  import efc_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Tick out
  output logic tick
);

  efc_tick_t st_q;
  efc_tick_t st_d;

  always_comb begin
    st_d = st_q;
    if (st_q.cnt == TICK_W'(DIV - 1)) begin
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + TICK_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = (st_q.cnt == TICK_W'(DIV - 1));

endmodule : efc_usec_tick

// File: test_efc_flash_ctrl.sv
// Self-checking testbench for the flash program/erase controller
module test_efc_flash_ctrl;
  import efc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, info_last;
  logic [31:0] paddr, pwdata, prdata, ardata;
  efc_fa_req_t fa_req;
  efc_fa_rsp_t fa_rsp;
  efc_array_t arr;
  int mismatches, compares, mass_cyc;
  logic [31:0] ra [9] = '{OFS_CTRL, OFS_HOLD, OFS_PULSE, OFS_PAGE, OFS_MASS, OFS_WAKE,
                          OFS_SEG, OFS_TOT_CNT, OFS_SEG_CNT};
  logic [31:0] rv [9] = '{32'h00020000, 32'h64, 32'h8, 32'h13880, 32'h13880, 32'h3,
                          32'h3e8, 32'h0, 32'h0};

  efc_flash_ctrl u_dut (.CLK_SYS(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FA_REQ(fa_req), .FA_RSP(fa_rsp), .ARRAY(arr), .ARRAY_RDATA(ardata));
  efc_array_model u_array (.clk(clk), .arr(arr), .rdata(ardata));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (arr.erase_en && arr.mass_en) begin
      mass_cyc <= mass_cyc + 1;
      info_last <= arr.info_sel;
    end
  end

  task report_and_stop;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Request is held until the edge at which pready is seen high
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic e;
    apb(1'b1, a, d, v, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr

  task rdchk(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] v;
    logic e;
    apb(1'b0, a, 32'h0, v, e);
    chk(v & m, exp);
  endtask : rdchk

  task fa(input logic w, input logic [17:0] a, input logic [31:0] d,
          output efc_fa_rsp_t r, output int n);
    @(posedge clk);
    fa_req <= '{1'b1, w, a, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (fa_rsp.done !== 1'b1);
    r = fa_rsp;
    fa_req.req <= 1'b0;
  endtask : fa

  task wait_idle;
    logic [31:0] v;
    logic e;
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_CTRL, 32'h0, v, e);
      k++;
    end while (v[6:4] !== 3'b000 && k < 500);
    chk({29'h0, v[6:4]}, 32'h0);
  endtask : wait_idle

  task t_regs;
    logic [31:0] v;
    logic e;
    for (int i = 0; i < 9; i++) rdchk(ra[i], rv[i], 32'hffffffff);
    apb(1'b1, 32'h50060200, 32'h5, v, e);
    chk({31'h0, e}, 32'h1);
    wr(OFS_TOT_CNT, 32'h123);
    rdchk(OFS_TOT_CNT, 32'h0, 32'hffffffff);
  endtask : t_regs

  task t_sleep;
    efc_fa_rsp_t r;
    int n;
    fa(1'b0, 18'h1, 32'h0, r, n);
    chk({31'h0, n >= 40 && n <= 70}, 32'h1);
    rdchk(OFS_CTRL, 32'h0, 32'h00020000);
    wr(OFS_CTRL, 32'h4);
    rdchk(OFS_CTRL, 32'h00020000, 32'h00020000);
    fa(1'b0, 18'h1, 32'h0, r, n);
    chk({31'h0, n >= 40}, 32'h1);
  endtask : t_sleep

  task t_write_erase;
    efc_fa_rsp_t r;
    int n;
    int m;
    wr(OFS_HOLD, 32'h2);
    wr(OFS_PULSE, 32'h3);
    wr(OFS_CTRL, 32'h9);
    fa(1'b1, 18'h5, 32'h1234abcd, r, n);
    chk({31'h0, r.err}, 32'h0);
    rdchk(OFS_CTRL, 32'h50, 32'h50);
    wait_idle();
    fa(1'b0, 18'h5, 32'h0, r, n);
    chk(r.rdata, 32'h1234abcd);
    wr(OFS_PAGE, 32'h4);
    wr(OFS_SEG, 32'h2);
    wr(OFS_CTRL, 32'ha);
    m = mass_cyc;
    fa(1'b1, 18'h20005, 32'h0, r, n);
    rdchk(OFS_CTRL, 32'h60, 32'h60);
    wait_idle();
    chk(mass_cyc, m);
    fa(1'b0, 18'h5, 32'h0, r, n);
    chk(r.rdata, 32'hffffffff);
    wr(OFS_MASS, 32'h3);
    wr(OFS_CTRL, 32'hb);
    m = mass_cyc;
    fa(1'b1, 18'h20000, 32'h0, r, n);
    wait_idle();
    chk({31'h0, info_last}, 32'h1);
    chk({31'h0, mass_cyc - m >= 40 && mass_cyc - m <= 62}, 32'h1);
    fa(1'b1, 18'h00010, 32'h0, r, n);
    wait_idle();
    chk({31'h0, info_last}, 32'h0);
  endtask : t_write_erase

  task t_suspend;
    efc_fa_rsp_t r;
    logic [31:0] v;
    logic e;
    int n;
    wr(OFS_PAGE, 32'h6);
    wr(OFS_CTRL, 32'h4000a);
    fa(1'b1, 18'h5, 32'h0, r, n);
    fa(1'b0, 18'h5, 32'h0, r, n);
    chk({31'h0, r.err}, 32'h0);
    rdchk(OFS_CTRL, 32'h60, 32'h100060);
    apb(1'b0, OFS_SEG_CNT, 32'h0, v, e);
    chk({31'h0, v >= 1 && v <= 2}, 32'h1);
    apb(1'b0, OFS_TOT_CNT, 32'h0, v, e);
    chk({31'h0, v >= 1 && v <= 6}, 32'h1);
    wr(OFS_CTRL, 32'hc000a);
    fa(1'b0, 18'h5, 32'h0, r, n);
    chk({31'h0, n <= 50}, 32'h1);
    wait_idle();
    rdchk(OFS_TOT_CNT, 32'h0, 32'hffffffff);
  endtask : t_suspend

  task t_locks;
    efc_fa_rsp_t r;
    int n;
    wr(OFS_CTRL, 32'h1);
    fa(1'b1, 18'h6, 32'h0, r, n);
    chk({31'h0, r.err}, 32'h1);
    wr(OFS_CTRL, 32'h8);
    fa(1'b1, 18'h6, 32'h0, r, n);
    chk({31'h0, r.err}, 32'h1);
    wr(OFS_CTRL, 32'h89);
    fa(1'b0, 18'h6, 32'h0, r, n);
    chk({31'h0, r.err}, 32'h1);
    wr(OFS_CTRL, 32'h9);
    fa(1'b0, 18'h6, 32'h0, r, n);
    chk({31'h0, r.err}, 32'h0);
    wr(OFS_CTRL, 32'h109);
    wr(OFS_CTRL, 32'h9);
    rdchk(OFS_CTRL, 32'h100, 32'h110);
    fa(1'b1, 18'h6, 32'h0, r, n);
    chk({31'h0, r.err}, 32'h1);
    wr(OFS_CTRL, 32'h200);
    fa(1'b0, 18'h6, 32'h0, r, n);
    chk({31'h0, r.err}, 32'h1);
    rdchk(OFS_CTRL, 32'h300, 32'h300);
  endtask : t_locks

  initial begin
    mismatches = 0;
    compares = 0;
    mass_cyc = 0;
    info_last = 1'b0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    fa_req = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_sleep();
    t_write_erase();
    t_suspend();
    t_locks();
    report_and_stop();
  end

  // All scenarios together take about a thousand cycles
  initial begin
    #2000000;
    mismatches++;
    report_and_stop();
  end
endmodule : test_efc_flash_ctrl
